// >>> ssrx_checker.sv
`timescale 1ns/1ps
module ssrx_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hready,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic rx_irq_line
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic rd, rd_stat, rise, armed;
  logic w_reg, sclk_reg, ovr_reg, clr_reg, s_reg;
  logic [7:0] a_reg, ctrl_reg, sh_reg, byte_reg;
  logic [2:0] mask_reg;
  logic [3:0] cnt_reg, quiet_reg;
  assign rd = hsel && htrans[1] && hready && !hwrite;
  assign rd_stat = rd && haddr[7:0] == ssrx_pkg::OFS_STAT;
  assign rise = sclk && !sclk_reg;
  assign armed = ctrl_reg[ssrx_pkg::CTRL_RE] && ctrl_reg[ssrx_pkg::CTRL_CM] &&
                 ctrl_reg[ssrx_pkg::CTRL_CKE + 1];
  // shadow writes land in the data phase, as in the device
  always_ff @(posedge sys_clk) begin
    a_reg <= haddr[7:0];
    w_reg <= !sys_rst && hsel && htrans[1] && hready && hwrite;
    if (sys_rst) begin
      ctrl_reg <= 8'h00;
      mask_reg <= 3'h0;
    end else if (w_reg && a_reg == ssrx_pkg::OFS_CTRL) begin
      ctrl_reg <= hwdata[7:0];
    end else if (w_reg && a_reg == ssrx_pkg::OFS_IRQ_MASK) begin
      mask_reg <= hwdata[2:0];
    end
  end
  // overrun last seen by software; clr marks a byte read not yet rechecked
  always_ff @(posedge sys_clk) begin
    s_reg <= rd_stat;
    if (sys_rst) begin
      ovr_reg <= 1'b0;
      clr_reg <= 1'b0;
    end else begin
      if (s_reg) ovr_reg <= hrdata[ssrx_pkg::ST_OVR];
      if (rd && haddr[7:0] == ssrx_pkg::OFS_DATA) clr_reg <= 1'b1;
      else if (rd_stat || (rise && cnt_reg == 4'h7)) clr_reg <= 1'b0;
    end
  end
  // raw link shadow; the device lags by its synchroniser, hence quiet_reg
  always_ff @(posedge sys_clk) begin
    sclk_reg <= sclk;
    if (sys_rst || rise) quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
    if (sys_rst || !armed) begin
      cnt_reg <= 4'h0;
    end else if (rise) begin
      sh_reg <= {sdata, sh_reg[7:1]};
      cnt_reg <= (cnt_reg == 4'h7) ? 4'h0 : cnt_reg + 4'h1;
      if (cnt_reg == 4'h7) byte_reg <= {sdata, sh_reg[7:1]};
    end
  end
  sequence byte_rd_s;
    rd && haddr[7:0] == ssrx_pkg::OFS_DATA && !rise && !ovr_reg &&
      quiet_reg > 4'h7;
  endsequence
  AST_BYTE_VALUE: assert property (
    byte_rd_s |=> hrdata == {24'h000000, $past(byte_reg)})
    else $error("byte read differs from lsb-first plain byte");
  AST_IRQ_DROP: assert property (
    byte_rd_s |-> ##[2:3] !rx_irq_line)
    else $error("interrupt kept after byte read");
  AST_FULL_CLR: assert property (
    rd_stat && clr_reg && quiet_reg > 4'h9 |=> !hrdata[0])
    else $error("full flag kept after byte read");
  AST_STAT_BITS: assert property (
    rd_stat |=> hrdata[31:2] == 30'h00000000)
    else $error("status shows an error other than overrun");
  AST_HOLD: assert property (
    !rd |=> $stable(hrdata))
    else $error("read data changed with no read");
  AST_IRQ_MASK: assert property (
    $past(mask_reg) == 3'h0 |-> !rx_irq_line)
    else $error("interrupt while every source is masked");
  AST_IRQ_RIE: assert property (
    $rose(rx_irq_line) |-> $past(ctrl_reg[ssrx_pkg::CTRL_RIE], 2))
    else $error("interrupt without receive interrupt enable");
  AST_IRQ_SYNC: assert property (
    $rose(rx_irq_line) |-> $past(ctrl_reg[ssrx_pkg::CTRL_CM], 2))
    else $error("reception outside clock-synchronous mode");
  AST_IRQ_EXT: assert property (
    $rose(rx_irq_line) |-> $past(ctrl_reg[ssrx_pkg::CTRL_CKE + 1], 2))
    else $error("reception without external clock select");
endmodule : ssrx_checker

// >>> ssrx_device.sv
`timescale 1ns/1ps
// Behaviour
// R1 - reading received byte clears full and pending
// R2 - overrun is the only receive error
// R3 - error interrupt goes through a group
// R4 - polling host checks overrun before full flag
// R5 - host reads byte when full, else rechecks
// R6 - host repeats until target byte count
// R7 - host ends by clearing enables then receiver
// R8 - per-source enable gates error into group
// R9 - clock select upper bit means external clock
// R10 - mode bit set selects clock-synchronous operation
// R11 - direction zero lsb first, invert zero plain
// R12 - host waits one bit period before enabling
// R13 - byte while full sets overrun, keeps old
module ssrx_device #(
  parameter int DATA_W = ssrx_pkg::BYTE_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  ssrx_if.dev_mp link,
  output logic rx_irq_line
);
  logic [7:0] ctrl_reg;
  logic [2:0] mask_reg;
  logic full_reg;
  logic ovr_reg;
  logic pend_rx_reg;
  logic pend_err_reg;
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] shift_reg;
  logic [DATA_W-1:0] shift_next;
  logic [$clog2(DATA_W)-1:0] bit_cnt_reg;
  logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic sdat_s1_reg, sdat_s2_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;
  logic acc, rd_data, rx_on, rise, byte_done, accept, ovr_evt;
  logic wr_ctrl, wr_stat, wr_istat, wr_mask;

  // bus slave: no wait states, always an OKAY answer
  assign link.hready = 1'b1;
  assign link.hresp = 1'b0;
  assign link.hrdata = rdata_reg;
  assign acc = link.hsel & link.htrans[1] & link.hready;
  assign rd_data = acc & ~link.hwrite &
                   (link.haddr[7:0] == ssrx_pkg::OFS_DATA);
  assign wr_ctrl = wr_pend_reg & (wr_addr_reg == ssrx_pkg::OFS_CTRL);
  assign wr_stat = wr_pend_reg & (wr_addr_reg == ssrx_pkg::OFS_STAT);
  assign wr_istat = wr_pend_reg &
                    (wr_addr_reg == ssrx_pkg::OFS_IRQ_STAT);
  assign wr_mask = wr_pend_reg & (wr_addr_reg == ssrx_pkg::OFS_IRQ_MASK);

  // address phase of a write is held until its data phase
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= acc & link.hwrite;
      wr_addr_reg <= link.haddr[7:0];
    end
  end

  // read mux; unmapped words read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (link.haddr[7:0])
      ssrx_pkg::OFS_CTRL: rd_mux[7:0] = ctrl_reg;
      ssrx_pkg::OFS_STAT: begin
        rd_mux[ssrx_pkg::ST_FULL] = full_reg;
        rd_mux[ssrx_pkg::ST_OVR] = ovr_reg;
      end
      ssrx_pkg::OFS_DATA: rd_mux[DATA_W-1:0] = data_reg;
      ssrx_pkg::OFS_IRQ_STAT: begin
        rd_mux[ssrx_pkg::IRQ_RX] = pend_rx_reg;
        rd_mux[ssrx_pkg::IRQ_ERR] = pend_err_reg;
      end
      ssrx_pkg::OFS_IRQ_MASK: rd_mux[2:0] = mask_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data is registered so it stands in the data phase
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (acc & ~link.hwrite) begin
      rdata_reg <= rd_mux;
    end
  end

  // control and mask registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_reg <= ssrx_pkg::CTRL_RST;
      mask_reg <= ssrx_pkg::MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= link.hwdata[7:0];
      end
      if (wr_mask) begin
        mask_reg <= link.hwdata[2:0];
      end
    end
  end

  // two-flop synchronisers for the pins; s3 only feeds edge detect
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sclk_s1_reg <= 1'b1;
      sclk_s2_reg <= 1'b1;
      sclk_s3_reg <= 1'b1;
      sdat_s1_reg <= 1'b1;
      sdat_s2_reg <= 1'b1;
    end else begin
      sclk_s1_reg <= link.sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      sdat_s1_reg <= link.sdata;
      sdat_s2_reg <= sdat_s1_reg;
    end
  end

  // receiver runs only in synchronous mode on the external clock
  assign rx_on = ctrl_reg[ssrx_pkg::CTRL_RE] &
                 ctrl_reg[ssrx_pkg::CTRL_CM] & // R10
                 ctrl_reg[ssrx_pkg::CTRL_CKE + 1]; // R9
  assign rise = rx_on & sclk_s2_reg & ~sclk_s3_reg;

  // bit order: lsb first shifts in from the top
  always_comb begin
    if (ctrl_reg[ssrx_pkg::CTRL_DIR]) begin
      shift_next = {shift_reg[DATA_W-2:0], sdat_s2_reg};
    end else begin
      shift_next = {sdat_s2_reg, shift_reg[DATA_W-1:1]}; // R11
    end
  end

  // shift register and bit counter; only the counter is cleared while disabled
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shift_reg <= '0;
      bit_cnt_reg <= '0;
    end else if (!rx_on) begin
      bit_cnt_reg <= '0;
    end else if (rise) begin
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
    end
  end

  assign byte_done = rise & (&bit_cnt_reg);
  // a read in the same cycle frees the register, so nothing is lost
  assign accept = byte_done & (~full_reg | rd_data);
  assign ovr_evt = byte_done & full_reg & ~rd_data; // R13

  // received byte register: old byte kept on overrun
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      data_reg <= '0;
    end else if (accept) begin
      if (ctrl_reg[ssrx_pkg::CTRL_INV]) begin
        data_reg <= ~shift_next;
      end else begin
        data_reg <= shift_next; // R11
      end
    end
  end

  // full flag: set wins, cleared only by reading the byte
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      full_reg <= 1'b0;
    end else if (accept) begin
      full_reg <= 1'b1;
    end else if (rd_data) begin
      full_reg <= 1'b0; // R1
    end
  end

  // overrun flag: only error kept in this mode, write one clears
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ovr_reg <= 1'b0;
    end else if (ovr_evt) begin
      ovr_reg <= 1'b1; // R2 R13
    end else if (wr_stat & link.hwdata[ssrx_pkg::ST_OVR]) begin
      ovr_reg <= 1'b0;
    end
  end

  // data request pending: cleared by the byte read or by write one
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_rx_reg <= 1'b0;
    end else if (accept & ctrl_reg[ssrx_pkg::CTRL_RIE]) begin
      pend_rx_reg <= 1'b1;
    end else if (rd_data |
                 (wr_istat & link.hwdata[ssrx_pkg::IRQ_RX])) begin
      pend_rx_reg <= 1'b0; // R1
    end
  end

  // per-source flag inside the error group, gated by its own enable
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_err_reg <= 1'b0;
    end else if (ovr_evt & ctrl_reg[ssrx_pkg::CTRL_RIE] &
                 mask_reg[ssrx_pkg::IRQ_GSRC]) begin
      pend_err_reg <= 1'b1; // R8
    end else if (wr_istat & link.hwdata[ssrx_pkg::IRQ_ERR]) begin
      pend_err_reg <= 1'b0;
    end
  end

  // one level line: data request or the error group
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_irq_line <= 1'b0;
    end else begin
      rx_irq_line <=
        (pend_rx_reg & mask_reg[ssrx_pkg::IRQ_RX]) |
        (pend_err_reg & mask_reg[ssrx_pkg::IRQ_ERR]); // R3
    end
  end
endmodule : ssrx_device

// >>> ssrx_host.sv
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module ssrx_host #(
  parameter int RX_LEN = ssrx_pkg::RX_LEN
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  ssrx_if.host_mp link,
  input wire logic start,
  input wire logic poll_mode,
  input wire logic irq_in,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_error,
  output logic busy,
  output logic done
);
  typedef enum logic [11:0] {
    S_IDLE = 12'h001, S_MASK = 12'h002, S_FMT = 12'h004,
    S_BITWAIT = 12'h008, S_EN = 12'h010, S_POLL = 12'h020,
    S_READ = 12'h040, S_CLROVR = 12'h080, S_CLRGRP = 12'h100,
    S_ENDMASK = 12'h200, S_ENDIRQ = 12'h400, S_ENDCTL = 12'h800
  } ssrx_step_type;
  typedef enum logic [2:0] {
    PH_IDLE = 3'h1, PH_ADDR = 3'h2, PH_DATA = 3'h4
  } ssrx_phase_type;

  // control and flag words built from the field positions
  localparam logic [7:0] FMT = 8'((1 << ssrx_pkg::CTRL_CM) |
                                  (1 << (ssrx_pkg::CTRL_CKE + 1)));
  localparam logic [7:0] EN_RX = 8'(1 << ssrx_pkg::CTRL_RE);
  localparam logic [7:0] EN_IRQ = 8'(1 << ssrx_pkg::CTRL_RIE);
  localparam logic [31:0] W1C_OVR = 32'(1 << ssrx_pkg::ST_OVR);
  localparam logic [31:0] W1C_GRP = 32'(1 << ssrx_pkg::IRQ_ERR);
  localparam logic [31:0] W1C_ALL = W1C_GRP | 32'(1 << ssrx_pkg::IRQ_RX);
  localparam logic [31:0] MASK_ALL = W1C_ALL | 32'(1 << ssrx_pkg::IRQ_GSRC);
  ssrx_step_type step_reg;
  ssrx_phase_type ph_reg;
  logic mode_poll_reg;
  logic [15:0] wait_reg;
  logic [$clog2(RX_LEN+1)-1:0] cnt_reg;
  logic [7:0] op_addr;
  logic op_wr;
  logic [31:0] op_wdata;
  logic op_go;
  logic [7:0] div_reg;
  logic [3:0] bits_reg;
  logic [7:0] txsh_reg;
  logic rx_live;

  // bus operation for each step of the receive sequence
  always_comb begin
    op_addr = ssrx_pkg::OFS_CTRL;
    op_wr = 1'b1;
    op_wdata = 32'h0000_0000;
    op_go = 1'b1;
    case (step_reg)
      S_MASK: begin
        op_addr = ssrx_pkg::OFS_IRQ_MASK;
        op_wdata = mode_poll_reg ? 32'h0000_0000 : MASK_ALL;
      end
      S_FMT: op_wdata = {24'h00_0000, FMT}; // R12
      S_EN: op_wdata = {24'h00_0000, FMT | EN_RX |
                        (mode_poll_reg ? 8'h00 : EN_IRQ)};
      S_POLL: begin
        op_addr = ssrx_pkg::OFS_STAT;
        op_wr = 1'b0;
        op_go = mode_poll_reg | irq_in; // R4
      end
      S_READ: begin
        op_addr = ssrx_pkg::OFS_DATA;
        op_wr = 1'b0;
      end
      S_CLROVR: begin
        op_addr = ssrx_pkg::OFS_STAT;
        op_wdata = W1C_OVR;
      end
      S_CLRGRP: begin
        op_addr = ssrx_pkg::OFS_IRQ_STAT;
        op_wdata = W1C_GRP;
      end
      S_ENDMASK: begin
        op_addr = ssrx_pkg::OFS_IRQ_MASK;
        op_wdata = 32'h0000_0000; // R7
      end
      S_ENDIRQ: begin
        op_addr = ssrx_pkg::OFS_IRQ_STAT;
        op_wdata = W1C_ALL; // R7
      end
      S_ENDCTL: op_wdata = 32'h0000_0000; // R7
      default: op_go = 1'b0;
    endcase
  end

  // sequence: one bus transfer per step except S_BITWAIT, then decide on its result
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      step_reg <= S_IDLE;
      ph_reg <= PH_IDLE;
      mode_poll_reg <= 1'b0;
      wait_reg <= 16'h0000;
      cnt_reg <= '0;
      link.hsel <= 1'b0;
      link.htrans <= ssrx_pkg::HTRANS_IDLE;
      link.haddr <= 32'h0000_0000;
      link.hwrite <= 1'b0;
      link.hsize <= ssrx_pkg::HSIZE_WORD;
      link.hwdata <= 32'h0000_0000;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_error <= 1'b0;
      done <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      rx_error <= 1'b0;
      done <= 1'b0;
      case (ph_reg)
        PH_IDLE: begin
          if (step_reg == S_IDLE) begin
            if (start) begin
              mode_poll_reg <= poll_mode;
              cnt_reg <= '0;
              step_reg <= S_MASK;
            end
          end else if (step_reg == S_BITWAIT) begin
            if (wait_reg >= 16'(ssrx_pkg::BIT_WAIT_CYC)) begin
              step_reg <= S_EN; // R12
            end
            wait_reg <= wait_reg + 16'h0001;
          end else if (op_go) begin
            link.hsel <= 1'b1;
            link.htrans <= ssrx_pkg::HTRANS_NONSEQ;
            link.haddr <= {24'h00_0000, op_addr};
            link.hwrite <= op_wr;
            link.hwdata <= op_wdata;
            ph_reg <= PH_ADDR;
          end
        end
        PH_ADDR: begin
          if (link.hready) begin
            link.htrans <= ssrx_pkg::HTRANS_IDLE;
            ph_reg <= PH_DATA;
          end
        end
        PH_DATA: begin
          if (link.hready) begin
            link.hsel <= 1'b0;
            ph_reg <= PH_IDLE;
            wait_reg <= 16'h0000;
            case (step_reg)
              S_MASK: step_reg <= S_FMT;
              S_FMT: step_reg <= S_BITWAIT;
              S_EN: step_reg <= S_POLL;
              S_POLL: begin
                if (link.hrdata[ssrx_pkg::ST_OVR]) begin
                  step_reg <= S_CLROVR; // R4
                end else if (link.hrdata[ssrx_pkg::ST_FULL]) begin
                  step_reg <= S_READ; // R5
                end
              end
              S_READ: begin
                rx_data <= link.hrdata[7:0]; // R5
                rx_valid <= 1'b1;
                cnt_reg <= cnt_reg + 1'b1;
                if (cnt_reg == ($bits(cnt_reg))'(RX_LEN - 1)) begin
                  step_reg <= S_ENDMASK; // R7
                end else begin
                  step_reg <= S_POLL; // R6
                end
              end
              S_CLROVR: begin
                rx_error <= 1'b1;
                step_reg <= S_CLRGRP;
              end
              S_CLRGRP: step_reg <= S_POLL;
              S_ENDMASK: step_reg <= S_ENDIRQ;
              S_ENDIRQ: step_reg <= S_ENDCTL;
              S_ENDCTL: begin
                done <= 1'b1;
                step_reg <= S_IDLE;
              end
              default: step_reg <= S_IDLE;
            endcase
          end
        end
        default: ph_reg <= PH_IDLE;
      endcase
    end
  end

  // bytes go out only once the receiver is on; earlier bits would be
  // clocked past a disabled receiver and shift every later byte
  assign busy = (step_reg != S_IDLE);
  assign rx_live = (step_reg == S_POLL) | (step_reg == S_READ) |
                   (step_reg == S_CLROVR) | (step_reg == S_CLRGRP);
  assign tx_ready = rx_live & (bits_reg == 4'h0);

  // link clock from a divider; data changes on falling, lsb first
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      link.sclk <= 1'b1;
      link.sdata <= 1'b1;
      div_reg <= 8'h00;
      bits_reg <= 4'h0;
      txsh_reg <= 8'h00;
    end else if (bits_reg == 4'h0) begin
      link.sclk <= 1'b1;
      div_reg <= 8'h00;
      if (tx_valid & tx_ready) begin
        txsh_reg <= tx_data;
        bits_reg <= 4'h8;
      end
    end else if (div_reg == 8'(ssrx_pkg::LINK_HALF_CYC - 1)) begin
      div_reg <= 8'h00;
      link.sclk <= ~link.sclk;
      if (link.sclk) begin
        link.sdata <= txsh_reg[0];
        txsh_reg <= {1'b0, txsh_reg[7:1]};
      end else begin
        bits_reg <= bits_reg - 4'h1;
      end
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end
endmodule : ssrx_host

// >>> ssrx_if.sv
`timescale 1ns/1ps
interface ssrx_if (
  input wire logic sys_clk,
  input wire logic sys_rst
);
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic sclk;
  logic sdata;

  modport dev_mp (
    input hsel, haddr, htrans, hwrite, hsize, hwdata, sclk, sdata,
    output hrdata, hready, hresp
  );
  modport host_mp (
    output hsel, haddr, htrans, hwrite, hsize, hwdata, sclk, sdata,
    input hrdata, hready, hresp
  );
endinterface : ssrx_if

// >>> ssrx_pkg.sv
package ssrx_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  // serial_control_reg fields
  localparam int CTRL_RE = 0;
  localparam int CTRL_RIE = 1;
  localparam int CTRL_CM = 2;
  localparam int CTRL_CKE = 3;
  localparam int CTRL_DIR = 5;
  localparam int CTRL_INV = 6;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // serial_status_reg fields
  localparam int ST_FULL = 0;
  localparam int ST_OVR = 1;
  // interrupt status / mask fields
  localparam int IRQ_RX = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_GSRC = 2;
  localparam logic [2:0] MASK_RST = 3'h0;
  // bus encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // timing
  localparam int SYS_CLK_MHZ = 100;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS * SYS_CLK_MHZ / 2000;
  localparam int BIT_WAIT_CYC = (LINK_PERIOD_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int RX_LEN = 32;
  localparam int BYTE_W = 8;
endpackage : ssrx_pkg

// >>> tb_sync_serial_slave_receiver.sv
`timescale 1ns/1ps
module tb_sync_serial_slave_receiver;
  logic sys_clk, sys_rst, start, poll_mode, tx_valid, irq, irq_hi;
  logic tx_ready, rx_valid, rx_error, busy, done;
  logic [7:0] tx_data, rx_data;
  logic [7:0] rxq[$];
  int fail_count, checked, errs;
  ssrx_if link_if (.sys_clk(sys_clk), .sys_rst(sys_rst));
  ssrx_device u_ssrx_device (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .link(link_if.dev_mp), .rx_irq_line(irq));
  ssrx_host #(.RX_LEN(4)) u_ssrx_host (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .link(link_if.host_mp), .start(start),
    .poll_mode(poll_mode), .irq_in(irq), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_error(rx_error), .busy(busy), .done(done));
  ssrx_checker u_ssrx_checker (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .hsel(link_if.hsel), .haddr(link_if.haddr), .htrans(link_if.htrans),
    .hwrite(link_if.hwrite), .hwdata(link_if.hwdata),
    .hrdata(link_if.hrdata), .hready(link_if.hready),
    .sclk(link_if.sclk), .sdata(link_if.sdata), .rx_irq_line(irq));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // sampled in the active region, so pre-edge values like the design sees
  always @(posedge sys_clk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (rx_error === 1'b1) errs++;
    if (irq === 1'b1) irq_hi = 1'b1;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // one session of four bytes, fed back to back, lowest byte of w first
  task automatic run(input logic pm, input logic [31:0] w);
    int n;
    rxq = {};
    errs = 0;
    irq_hi = 1'b0;
    n = 0;
    poll_mode <= pm;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      tx_data <= w[8*i +: 8];
      tx_valid <= 1'b1;
      do @(posedge sys_clk); while (tx_ready !== 1'b1 && ++n < 5000);
    end
    tx_valid <= 1'b0;
    while (done !== 1'b1 && ++n < 5000) @(posedge sys_clk);
    cmp({31'h0, done}, 32'h00000001);
    cmp(32'(rxq.size()), 32'h00000004);
    for (int i = 0; i < rxq.size() && i < 4; i++) begin
      cmp({24'h000000, rxq[i]}, {24'h000000, w[8*i +: 8]});
    end
    cmp(32'(errs), 32'h00000000);
    cmp({31'h0, irq_hi}, {31'h0, !pm});
    // the closing writes need a few cycles to drop the line
    repeat (3) @(posedge sys_clk);
    cmp({31'h0, irq}, 32'h00000000);
    cmp({31'h0, busy}, 32'h00000000);
    cmp({31'h0, link_if.sclk}, 32'h00000001);
    $display("session poll=%0d ended at %0t", pm, $time);
  endtask : run
  initial begin
    sys_rst = 1'b1;
    start = 1'b0;
    poll_mode = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    irq_hi = 1'b0;
    fail_count = 0;
    checked = 0;
    errs = 0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    cmp({31'h0, link_if.sclk}, 32'h00000001);
    cmp({31'h0, irq}, 32'h00000000);
    run(1'b0, 32'h01A5FF00);
    run(1'b1, 32'hC33C7F80);
    run(1'b0, 32'h80000001);
    end_of_test();
  end
  // three sessions take about 1750 cycles; over fifteen times that is a hang
  initial begin
    #300000;
    fail_count++;
    end_of_test();
  end
endmodule : tb_sync_serial_slave_receiver
